// [opmg_pkg.sv]
// constants shared by the output path control block
// assumes one system clock and the documented register word addresses
`default_nettype none

package opmg_pkg;

  // register word addresses
  localparam logic [7:0] ADDR_LINE   = 8'h02;
  localparam logic [7:0] ADDR_SPK    = 8'h03;
  localparam logic [7:0] ADDR_MIX    = 8'h07;
  localparam logic [7:0] ADDR_BOOST  = 8'h09;
  localparam logic [7:0] ADDR_MODE   = 8'h0a;
  localparam logic [7:0] ADDR_PWR    = 8'h0b;
  localparam logic [7:0] ADDR_DACVOL = 8'h1e;
  localparam logic [7:0] ADDR_DAC2   = 8'h1f;

  // field positions
  localparam int LVL_MUTE_BIT  = 7;
  localparam int LVL_ZC_BIT    = 6;
  localparam int MIX_DAC_BIT   = 4;
  localparam int MIX_IN2_ATT   = 3;
  localparam int MIX_IN2_EN    = 2;
  localparam int MIX_IN1_ATT   = 1;
  localparam int MIX_IN1_EN    = 0;
  localparam int BOOST_DC_LSB  = 3;
  localparam int BOOST_AC_LSB  = 0;
  localparam int MODE_CLASS_AB = 6;
  localparam int MODE_GUARD_A  = 4;
  localparam int MODE_GUARD_B  = 3;
  localparam int PWR_LINE_EN   = 4;
  localparam int PWR_PGA_EN    = 2;
  localparam int PWR_SPK_EN    = 1;
  localparam int PWR_DAC_EN    = 0;
  localparam int DAC2_RATE_BIT = 10;
  localparam int DAC2_MODE_BIT = 9;
  localparam int DAC2_MUTE_BIT = 3;
  localparam int DAC2_DEEMPHASIS_SELECT   = 1;

  // writable bits, others read as zero
  localparam logic [15:0] MASK_LVL    = 16'h00ff;
  localparam logic [15:0] MASK_MIX    = 16'h001f;
  localparam logic [15:0] MASK_BOOST  = 16'h003f;
  localparam logic [15:0] MASK_MODE   = 16'h0058;
  localparam logic [15:0] MASK_PWR    = 16'h0017;
  localparam logic [15:0] MASK_DACVOL = 16'h00ff;
  localparam logic [15:0] MASK_DAC2   = 16'h060e;

  // values after reset
  localparam logic [15:0] RST_LVL    = 16'h00b9;
  localparam logic [15:0] RST_MIX    = 16'h0000;
  localparam logic [15:0] RST_BOOST  = 16'h001b;
  localparam logic [15:0] RST_MODE   = 16'h0018;
  localparam logic [15:0] RST_PWR    = 16'h0000;
  localparam logic [15:0] RST_DACVOL = 16'h00c0;
  localparam logic [15:0] RST_DAC2   = 16'h0008;
  localparam logic [5:0]  RST_VOL6   = 6'h39;

  // digital volume full scale code (0dB)
  localparam logic [7:0]  DIGITAL_VOLUME_CODE_MAX = 8'hc0;

  typedef enum logic {GAIN_SETTLED, GAIN_RAMPING} opmg_gain_e;

endpackage : opmg_pkg

`default_nettype wire

// [opmg_zc_if.sv]
// carrier between the control top and one zero-cross volume holder
// assumes the top drives requests and the holder returns applied volume
`default_nettype none

interface opmg_zc_if;
  logic       zc_en;
  logic [5:0] vol_req;
  logic       zero_cross;
  logic       timeout_tick;
  logic [5:0] vol_applied;

  modport ctrl (output zc_en, vol_req, zero_cross, timeout_tick,
                input  vol_applied);
  modport unit (input  zc_en, vol_req, zero_cross, timeout_tick,
                output vol_applied);
endinterface : opmg_zc_if

`default_nettype wire

// [opmg_zc_hold.sv]
// zero-cross gated volume holder for one analogue gain stage
// assumes zero_cross and timeout_tick are one-cycle pulses on clk
`default_nettype none

module opmg_zc_hold
  import opmg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  opmg_zc_if.unit  zc
);

  logic [5:0] vol_q;
  logic [5:0] vol_d;
  logic       take;

  // immediate when gating off, else only at a crossing or timeout
  assign take  = !zc.zc_en || zc.zero_cross || zc.timeout_tick;
  assign vol_d = take ? zc.vol_req : vol_q;

  // applied gain, reset to 0dB
  always_ff @(posedge clk) begin
    if (srst) begin
      vol_q <= RST_VOL6;
    end else begin
      vol_q <= vol_d;
    end
  end

  assign zc.vol_applied = vol_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_zc_holds_value:
    assert property (zc.zc_en && !zc.zero_cross && !zc.timeout_tick
                     |=> $stable(zc.vol_applied))
    else $error("volume changed without crossing or timeout");

  a_zc_off_immediate:
    assert property (!zc.zc_en |=> zc.vol_applied == $past(zc.vol_req))
    else $error("volume not applied at once with gating off");

  a_zc_timeout_apply:
    assert property (zc.zc_en && zc.timeout_tick && !zc.zero_cross
                     |=> zc.vol_applied == $past(zc.vol_req))
    else $error("pending volume not applied at timeout");

endmodule : opmg_zc_hold

`default_nettype wire

// [opmg_output_ctrl.sv]
// output path register bank: dac soft mute, mixer, line and speaker gain
// assumes a word-addressed register port and a one-cycle sample tick
`default_nettype none

module opmg_output_ctrl
  import opmg_pkg::*;
#(
  parameter int RAMP_FAST_DIV = 2,
  parameter int RAMP_SLOW_DIV = 32
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        FS_TICK,
  input  wire logic        LINE_ZERO_CROSS,
  input  wire logic        SPK_ZERO_CROSS,
  input  wire logic        TIMEOUT_TICK,
  output logic      [7:0]  DAC_GAIN,
  output logic             DAC_ENABLE,
  output logic      [1:0]  DEEMPHASIS_SELECT,
  output logic             DAC_TO_MIXER,
  output logic             LINE_INPUT_ONE_ENABLE,
  output logic             LINE_INPUT_ONE_ATTENUATE,
  output logic             LINE_INPUT_TWO_ENABLE,
  output logic             LINE_INPUT_TWO_ATTENUATE,
  output logic             LINE_DRIVER_ENABLE,
  output logic             LINE_DRIVER_MUTE,
  output logic      [5:0]  LINE_DRIVER_VOLUME,
  output logic             SPEAKER_PREAMP_ENABLE,
  output logic             SPEAKER_PREAMP_MUTE,
  output logic      [5:0]  SPEAKER_PREAMP_VOLUME,
  output logic             SPEAKER_STAGE_ENABLE,
  output logic             SPEAKER_POP_GUARD_A,
  output logic             SPEAKER_POP_GUARD_B,
  output logic             AMPLIFIER_CLASS_SELECT,
  output logic      [2:0]  SPEAKER_DC_BOOST,
  output logic      [2:0]  SPEAKER_AC_BOOST
);

  // ramp counter is five bits wide
  if (RAMP_FAST_DIV < 1 || RAMP_FAST_DIV > 32 ||
      RAMP_SLOW_DIV < 1 || RAMP_SLOW_DIV > 32) begin : g_bad_div
    $error("ramp divisors must lie in 1..32");
  end

  // limit reserved volume codes to full scale
  function automatic logic [7:0] clamp_vol(input logic [7:0] v);
    return (v > DIGITAL_VOLUME_CODE_MAX) ? DIGITAL_VOLUME_CODE_MAX : v;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] at);
    return a == at;
  endfunction

  logic [15:0] line_q, spk_q, mix_q, boost_q, mode_q, pwr_q, dvol_q, dac2_q;
  logic [15:0] rdata_q;
  logic [15:0] read_mux;
  logic [7:0]  gain_q, gain_d, target;
  logic [4:0]  rate_cnt_q, ramp_div;
  opmg_gain_e  state_q, state_d;
  logic        wr_line, wr_spk, wr_mix, wr_boost, wr_mode, wr_pwr;
  logic        wr_dvol, wr_dac2;
  logic        soft_mute, unmute_now, step_en, instant_follow, class_ab;

  // write strobes per register
  assign wr_line  = REG_WR && hit(REG_ADDR, ADDR_LINE);
  assign wr_spk   = REG_WR && hit(REG_ADDR, ADDR_SPK);
  assign wr_mix   = REG_WR && hit(REG_ADDR, ADDR_MIX);
  assign wr_boost = REG_WR && hit(REG_ADDR, ADDR_BOOST);
  assign wr_mode  = REG_WR && hit(REG_ADDR, ADDR_MODE);
  assign wr_pwr   = REG_WR && hit(REG_ADDR, ADDR_PWR);
  assign wr_dvol  = REG_WR && hit(REG_ADDR, ADDR_DACVOL);
  assign wr_dac2  = REG_WR && hit(REG_ADDR, ADDR_DAC2);

  // plain storage registers; reserved boost codes stored as written
  always_ff @(posedge CLK) begin
    if (SRST) begin
      line_q  <= RST_LVL;
      spk_q   <= RST_LVL;
      mix_q   <= RST_MIX;
      boost_q <= RST_BOOST;
      pwr_q   <= RST_PWR;
      dvol_q  <= RST_DACVOL;
      dac2_q  <= RST_DAC2;
    end else begin
      if (wr_line)  line_q  <= REG_WDATA & MASK_LVL;
      if (wr_spk)   spk_q   <= REG_WDATA & MASK_LVL;
      if (wr_mix)   mix_q   <= REG_WDATA & MASK_MIX;
      if (wr_boost) boost_q <= REG_WDATA & MASK_BOOST;
      if (wr_pwr)   pwr_q   <= REG_WDATA & MASK_PWR;
      if (wr_dvol)  dvol_q  <= REG_WDATA & MASK_DACVOL;
      if (wr_dac2)  dac2_q  <= REG_WDATA & MASK_DAC2;
    end
  end

  // class select and pop guards; in class d a power write drives the
  // guards, class ab leaves them to the host
  assign class_ab = mode_q[MODE_CLASS_AB];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_q <= RST_MODE;
    end else if (wr_mode) begin
      mode_q <= REG_WDATA & MASK_MODE;
    end else if (wr_pwr && !class_ab) begin
      mode_q[MODE_GUARD_A] <= !REG_WDATA[PWR_SPK_EN];
      mode_q[MODE_GUARD_B] <= !REG_WDATA[PWR_SPK_EN];
    end
  end

  // dac soft mute and ramp; fast path follows volume whenever unmuted in mode 0
  assign soft_mute      = dac2_q[DAC2_MUTE_BIT];
  assign target         = soft_mute ? 8'h00 : clamp_vol(dvol_q[7:0]);
  assign unmute_now     = wr_dac2 && soft_mute &&
                          !REG_WDATA[DAC2_MUTE_BIT] &&
                          !REG_WDATA[DAC2_MODE_BIT];
  assign instant_follow = !soft_mute && !dac2_q[DAC2_MODE_BIT];
  assign ramp_div       = dac2_q[DAC2_RATE_BIT] ?
                          5'(RAMP_SLOW_DIV - 1) :
                          5'(RAMP_FAST_DIV - 1);
  assign step_en        = FS_TICK && (state_q == GAIN_RAMPING) &&
                          (rate_cnt_q == ramp_div);

  // one 0.375dB code per ramp step toward the target
  always_comb begin
    gain_d = gain_q;
    if (unmute_now) begin
      gain_d = clamp_vol(dvol_q[7:0]);
    end else if (instant_follow) begin
      gain_d = target;
    end else if (step_en) begin
      if (gain_q < target) begin
        gain_d = gain_q + 8'h01;
      end else if (gain_q > target) begin
        gain_d = gain_q - 8'h01;
      end
    end
  end

  assign state_d = (gain_d != target) ? GAIN_RAMPING : GAIN_SETTLED;

  // gain register starts at zero since the dac starts muted
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gain_q  <= 8'h00;
      state_q <= GAIN_SETTLED;
    end else begin
      gain_q  <= gain_d;
      state_q <= state_d;
    end
  end

  // sample tick divider, restarts whenever the gain has settled
  always_ff @(posedge CLK) begin
    if (SRST || state_q == GAIN_SETTLED) begin
      rate_cnt_q <= 5'h00;
    end else if (FS_TICK) begin
      rate_cnt_q <= step_en ? 5'h00 : rate_cnt_q + 5'h01;
    end
  end

  // zero-cross volume holders for line driver and speaker preamp
  opmg_zc_if line_zc ();
  opmg_zc_if spk_zc ();

  assign line_zc.zc_en        = line_q[LVL_ZC_BIT];
  assign line_zc.vol_req      = line_q[5:0];
  assign line_zc.zero_cross   = LINE_ZERO_CROSS;
  assign line_zc.timeout_tick = TIMEOUT_TICK;
  assign spk_zc.zc_en         = spk_q[LVL_ZC_BIT];
  assign spk_zc.vol_req       = spk_q[5:0];
  assign spk_zc.zero_cross    = SPK_ZERO_CROSS;
  assign spk_zc.timeout_tick  = TIMEOUT_TICK;

  opmg_zc_hold u_line_hold (
    .clk  (CLK),
    .srst (SRST),
    .zc   (line_zc)
  );

  opmg_zc_hold u_spk_hold (
    .clk  (CLK),
    .srst (SRST),
    .zc   (spk_zc)
  );

  // readback select, unmapped words read zero
  assign read_mux = hit(REG_ADDR, ADDR_LINE)   ? line_q  :
                    hit(REG_ADDR, ADDR_SPK)    ? spk_q   :
                    hit(REG_ADDR, ADDR_MIX)    ? mix_q   :
                    hit(REG_ADDR, ADDR_BOOST)  ? boost_q :
                    hit(REG_ADDR, ADDR_MODE)   ? mode_q  :
                    hit(REG_ADDR, ADDR_PWR)    ? pwr_q   :
                    hit(REG_ADDR, ADDR_DACVOL) ? dvol_q  :
                    hit(REG_ADDR, ADDR_DAC2)   ? dac2_q  : 16'h0000;

  // read data held until the next read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= 16'h0000;
    end else if (REG_RD) begin
      rdata_q <= read_mux;
    end
  end

  // outputs, each straight from a flip-flop
  assign REG_RDATA                = rdata_q;
  assign DAC_GAIN                 = gain_q;
  assign DAC_ENABLE               = pwr_q[PWR_DAC_EN];
  assign DEEMPHASIS_SELECT        = dac2_q[DAC2_DEEMPHASIS_SELECT +: 2];
  assign DAC_TO_MIXER             = mix_q[MIX_DAC_BIT];
  assign LINE_INPUT_ONE_ENABLE    = mix_q[MIX_IN1_EN];
  assign LINE_INPUT_ONE_ATTENUATE = mix_q[MIX_IN1_ATT];
  assign LINE_INPUT_TWO_ENABLE    = mix_q[MIX_IN2_EN];
  assign LINE_INPUT_TWO_ATTENUATE = mix_q[MIX_IN2_ATT];
  assign LINE_DRIVER_ENABLE       = pwr_q[PWR_LINE_EN];
  assign LINE_DRIVER_MUTE         = line_q[LVL_MUTE_BIT];
  assign LINE_DRIVER_VOLUME       = line_zc.vol_applied;
  assign SPEAKER_PREAMP_ENABLE    = pwr_q[PWR_PGA_EN];
  assign SPEAKER_PREAMP_MUTE      = spk_q[LVL_MUTE_BIT];
  assign SPEAKER_PREAMP_VOLUME    = spk_zc.vol_applied;
  assign SPEAKER_STAGE_ENABLE     = pwr_q[PWR_SPK_EN];
  assign SPEAKER_POP_GUARD_A      = mode_q[MODE_GUARD_A];
  assign SPEAKER_POP_GUARD_B      = mode_q[MODE_GUARD_B];
  assign AMPLIFIER_CLASS_SELECT   = class_ab;
  assign SPEAKER_DC_BOOST         = boost_q[BOOST_DC_LSB +: 3];
  assign SPEAKER_AC_BOOST         = boost_q[BOOST_AC_LSB +: 3];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_unmute_instant_gain:
    assert property (unmute_now
                     |=> DAC_GAIN == clamp_vol($past(dvol_q[7:0])))
    else $error("instant unmute did not restore volume");

  a_soft_mute_write:
    assert property (wr_dac2 && REG_WDATA[DAC2_MUTE_BIT]
                     |=> soft_mute ##1 (DAC_GAIN <= $past(DAC_GAIN)))
    else $error("mute write did not mute");

  a_ramp_single_step:
    assert property (dac2_q[DAC2_MODE_BIT] && !unmute_now && !wr_dac2
                     && !wr_dvol && $changed(DAC_GAIN) |->
                     (DAC_GAIN == $past(DAC_GAIN) + 8'h01 ||
                      DAC_GAIN == $past(DAC_GAIN) - 8'h01))
    else $error("ramp moved by more than one code");

  a_ramp_step_spacing:
    assert property (step_en && !dac2_q[DAC2_RATE_BIT] &&
                     (RAMP_FAST_DIV > 1) |=> !step_en)
    else $error("fast ramp stepped twice without a sample tick");

  a_guard_auto_update:
    assert property (wr_pwr && !class_ab |=>
                     SPEAKER_POP_GUARD_A == !$past(REG_WDATA[PWR_SPK_EN])
                     && SPEAKER_POP_GUARD_B == SPEAKER_POP_GUARD_A)
    else $error("class d pop guards not updated on power write");

  a_guard_class_ab:
    assert property (wr_pwr && class_ab |=>
                     $stable(SPEAKER_POP_GUARD_A) &&
                     $stable(SPEAKER_POP_GUARD_B))
    else $error("class ab pop guards changed by hardware");

  a_mixer_write:
    assert property (wr_mix |=>
                     LINE_INPUT_TWO_ATTENUATE == $past(REG_WDATA[3]) &&
                     DAC_TO_MIXER == $past(REG_WDATA[4]))
    else $error("mixer select not taken");

  a_boost_write:
    assert property (wr_boost |=>
                     SPEAKER_DC_BOOST == $past(REG_WDATA[5:3]) &&
                     SPEAKER_AC_BOOST == $past(REG_WDATA[2:0]))
    else $error("boost fields not taken");

endmodule : opmg_output_ctrl

`default_nettype wire

// [opmg_host_model.sv]
// host model: writes and reads the output path control registers
// assumes the bank takes a one-cycle strobe on a rising clk edge
`default_nettype none

module opmg_host_model
  import opmg_pkg::*;
(
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] pwr_shadow;  // last power word written

  // idle bus at time zero
  initial begin
    reg_addr   = 8'h00;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    pwr_shadow = 16'h0000;
  end

  // lines scrambled once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    if (a == ADDR_PWR) pwr_shadow = d;
  endtask

  // read data is registered, taken just after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // preamp first, then stage; reverse on the way down
  task automatic speaker_up();
    wr(ADDR_PWR, pwr_shadow | 16'h0004);
    wr(ADDR_PWR, pwr_shadow | 16'h0006);
  endtask
  task automatic speaker_down();
    wr(ADDR_PWR, pwr_shadow & ~16'h0002);
    wr(ADDR_PWR, pwr_shadow & ~16'h0004);
  endtask

  // class ab leaves the guards to us, so clear them with the mode
  task automatic enter_class_ab();
    wr(ADDR_MODE, 16'h0040);
  endtask

  // boost changes only with the speaker off, a live change pops
  task automatic set_boost(input logic [15:0] d);
    if (pwr_shadow[PWR_SPK_EN]) speaker_down();
    wr(ADDR_BOOST, d);
  endtask
endmodule // opmg_host_model

`default_nettype wire

// [opmg_output_ctrl_tb.sv]
// self-checking bench for the output path control register bank
// assumes the host model on the register port; pulses driven here
`default_nettype none

module opmg_output_ctrl_tb;
  import opmg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        srst;
  logic [3:0]  pls;  // fs tick, line zc, speaker zc, timeout
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  dac_gain;
  logic [1:0]  deemphasis_select;
  logic [5:0]  line_vol;
  logic [5:0]  spk_vol;
  logic [2:0]  dc_boost;
  logic [2:0]  ac_boost;
  logic        dac_en, dac_mix, in1_en, in1_att, in2_en, in2_att;
  logic        line_en, line_mute, pga_en, pga_mute, stg_en;
  logic        guard_a, guard_b, cls;
  int          err_count;
  int          samples_checked;

  // outputs packed in register layout for one-line comparisons
  wire logic [15:0] mix_obs  = {11'h0, dac_mix, in2_att, in2_en,
                                in1_att, in1_en};
  wire logic [15:0] pwr_obs  = {11'h0, line_en, 1'b0, pga_en, stg_en,
                                dac_en};
  wire logic [15:0] mode_obs = {9'h0, cls, 1'b0, guard_a, guard_b, 3'h0};
  wire logic [15:0] bst_obs  = {10'h0, dc_boost, ac_boost};

  always #4 clk = ~clk;

  opmg_host_model opmg_host_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  opmg_output_ctrl #(.RAMP_FAST_DIV(2), .RAMP_SLOW_DIV(32))
  opmg_output_ctrl_i (
    .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FS_TICK(pls[0]), .LINE_ZERO_CROSS(pls[1]), .SPK_ZERO_CROSS(pls[2]),
    .TIMEOUT_TICK(pls[3]), .DAC_GAIN(dac_gain), .DAC_ENABLE(dac_en),
    .DEEMPHASIS_SELECT(deemphasis_select), .DAC_TO_MIXER(dac_mix),
    .LINE_INPUT_ONE_ENABLE(in1_en), .LINE_INPUT_ONE_ATTENUATE(in1_att),
    .LINE_INPUT_TWO_ENABLE(in2_en), .LINE_INPUT_TWO_ATTENUATE(in2_att),
    .LINE_DRIVER_ENABLE(line_en), .LINE_DRIVER_MUTE(line_mute),
    .LINE_DRIVER_VOLUME(line_vol), .SPEAKER_PREAMP_ENABLE(pga_en),
    .SPEAKER_PREAMP_MUTE(pga_mute), .SPEAKER_PREAMP_VOLUME(spk_vol),
    .SPEAKER_STAGE_ENABLE(stg_en), .SPEAKER_POP_GUARD_A(guard_a),
    .SPEAKER_POP_GUARD_B(guard_b), .AMPLIFIER_CLASS_SELECT(cls),
    .SPEAKER_DC_BOOST(dc_boost), .SPEAKER_AC_BOOST(ac_boost));

  // two edges cover register and applied-volume latency
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    opmg_host_model_i.wr(a, d);
    settle();
  endtask
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      pls[idx] <= 1'b1;
      @(posedge clk);
      pls[idx] <= 1'b0;
    end
    settle();
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] got;
    opmg_host_model_i.rd(a, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: read %h got %h want %h", $time, a, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: output got %h want %h", $time, got, exp);
    end
  endtask

  // values straight out of reset, unmapped read included
  task automatic t_reset();
    chk_rd(ADDR_LINE, 16'h00b9);
    chk_rd(ADDR_SPK, 16'h00b9);
    chk_rd(ADDR_MIX, 16'h0000);
    chk_rd(ADDR_BOOST, 16'h001b);
    chk_rd(ADDR_MODE, 16'h0018);
    chk_rd(ADDR_PWR, 16'h0000);
    chk_rd(ADDR_DAC2, 16'h0008);
    chk_rd(8'h05, 16'h0000);
    chk_rd(ADDR_DACVOL, 16'h00c0);
    chk_pin(16'({line_mute, line_vol}), 16'h0079);
    chk_pin(16'({pga_mute, spk_vol}), 16'h0079);
    chk_pin(16'({dac_gain, deemphasis_select}), 16'h0000);
    chk_pin(mode_obs, 16'h0018);
    chk_pin(bst_obs, 16'h001b);
  endtask

  // every mixer pattern with junk above the field, every de-emphasis code
  task automatic t_mixer();
    for (int i = 0; i < 32; i++) begin
      wr_reg(ADDR_MIX, 16'hffe0 | 16'(i));
      chk_pin(mix_obs, 16'(i));
      chk_rd(ADDR_MIX, 16'(i));
    end
    for (int d = 0; d < 4; d++) begin
      wr_reg(ADDR_DAC2, 16'h0008 | 16'(d << 1));
      chk_pin(16'(deemphasis_select), 16'(d));
    end
  endtask

  // instant unmute, volume codes, then fast and slow ramps
  task automatic t_dac();
    wr_reg(ADDR_DAC2, 16'h0000);
    chk_pin(16'(dac_gain), 16'h00c0);
    wr_reg(ADDR_DACVOL, 16'h0000);
    chk_pin(16'(dac_gain), 16'h0000);
    wr_reg(ADDR_DACVOL, 16'h0001);
    chk_pin(16'(dac_gain), 16'h0001);
    wr_reg(ADDR_DACVOL, 16'h00ff);
    chk_pin(16'(dac_gain), 16'h00c0);
    wr_reg(ADDR_DACVOL, 16'h00c0);
    wr_reg(ADDR_DAC2, 16'h0008);
    pulse(0, 1);
    chk_pin(16'(dac_gain), 16'h00c0);
    pulse(0, 1);
    chk_pin(16'(dac_gain), 16'h00bf);
    wr_reg(ADDR_DAC2, 16'h0200);
    pulse(0, 1);
    chk_pin(16'(dac_gain), 16'h00bf);
    pulse(0, 3);
    chk_pin(16'(dac_gain), 16'h00c0);
    wr_reg(ADDR_DAC2, 16'h0408);
    pulse(0, 31);
    chk_pin(16'(dac_gain), 16'h00c0);
    pulse(0, 1);
    chk_pin(16'(dac_gain), 16'h00bf);
  endtask

  // held volume waits for its own crossing or the timeout
  task automatic t_zc();
    wr_reg(ADDR_LINE, 16'h0050);
    chk_pin(16'({line_mute, line_vol}), 16'h0039);
    pulse(2, 1);
    chk_pin(16'({line_mute, line_vol}), 16'h0039);
    pulse(1, 1);
    chk_pin(16'({line_mute, line_vol}), 16'h0010);
    wr_reg(ADDR_LINE, 16'h0020);
    chk_pin(16'({line_mute, line_vol}), 16'h0020);
    wr_reg(ADDR_SPK, 16'h0045);
    chk_pin(16'({pga_mute, spk_vol}), 16'h0039);
    pulse(3, 1);
    chk_pin(16'({pga_mute, spk_vol}), 16'h0005);
  endtask

  // guards follow the stage write in class d, stay put in class ab
  task automatic t_power();
    wr_reg(ADDR_PWR, 16'h0011);
    chk_pin(pwr_obs, 16'h0011);
    opmg_host_model_i.speaker_up();
    settle();
    chk_pin(pwr_obs, 16'h0017);
    chk_pin(mode_obs, 16'h0000);
    opmg_host_model_i.speaker_down();
    settle();
    chk_pin(pwr_obs, 16'h0011);
    chk_pin(mode_obs, 16'h0018);
    opmg_host_model_i.enter_class_ab();
    settle();
    chk_rd(ADDR_MODE, 16'h0040);
    opmg_host_model_i.speaker_up();
    settle();
    chk_pin(mode_obs, 16'h0040);
  endtask

  // every boost code on both fields, reserved ones included
  task automatic t_boost();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = 16'({3'(i), 3'(7 - i)});
      opmg_host_model_i.set_boost(d);
      settle();
      chk_pin(bst_obs, d);
      chk_rd(ADDR_BOOST, d);
    end
    chk_pin(mode_obs, 16'h0040);
  endtask

  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence, with a second reset at the end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    pls = 4'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_mixer();
    t_dac();
    t_zc();
    t_power();
    t_boost();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_rd(ADDR_MODE, 16'h0018);
    chk_rd(ADDR_DAC2, 16'h0008);
    give_verdict();
  end

  // hang guard, far above the normal run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule // opmg_output_ctrl_tb

`default_nettype wire
